// ---- verilog/rpc_consts.svh ----
// Offsets, fields, reset values and timing counts of the receive payload conditioner
//
// How it works
// - Busy flag stays one during an indirect access; new operations are refused.
// - One indirect access lasts 490 ns; busy clears on a clock edge after.
// - Valid address plus command written to address/control starts one operation.
// - Direction zero writes buffer to indirect register, one reads into buffer.
// - Seven-bit indirect address selects 20H to 7FH except 60H; host stays within range.
// - Indirect read places the requested byte in the data buffer after 490 ns.
// - Slot config at 20H-3FH, trunk codes 40H-5FH, signaling nibbles 61H-7FH.
// - Test bit extracts slot to pattern detector, or replaces it with pattern.
// - Extracted and replaced slots each form one continuous pattern stream.
// - Data trunk bit outputs the slot's trunk code, bit 7 most significant.
// - In slave fractional mode the same bit holds the slave clock inactive.
// - Signaling trunk bit outputs the stored ABCD nibble instead of signaling.
// - Milliwatt bit replaces slot; law select zero mu-law, one A-law.
// - Without sign invert, select gives none, even, odd or all bits inverted.
// - With sign invert: MSB; bits 1,2,4,6,8; bits 3,5,7; all but MSB.
// - Only highest-priority operation applies: test extraction, trunk, milliwatt, pattern replacement, inversion.
// - Per-slot functions enable gates every per-slot operation.
`ifndef RPC_CONSTS_SVH
`define RPC_CONSTS_SVH

// Direct register offsets
`define RPC_ADDR_CONFIG      8'h5C
`define RPC_ADDR_STATUS      8'h5D
`define RPC_ADDR_CTRL        8'h5E
`define RPC_ADDR_DATA        8'h5F

// Reset values
`define RPC_RST_CONFIG       8'h00
`define RPC_RST_CTRL         8'h00
`define RPC_RST_DATA         8'h00

// Field positions
`define RPC_STATUS_BUSY_BIT  7
`define RPC_CTRL_DIR_BIT     7
`define RPC_CONFIG_EN_BIT    0
`define RPC_CFG_TEST_BIT     7
`define RPC_CFG_DTRK_BIT     6
`define RPC_CFG_STRK_BIT     5
`define RPC_CFG_MW_BIT       4
`define RPC_CFG_ALAW_BIT     3
`define RPC_CFG_SIGN_BIT     2

// Indirect address ranges
`define RPC_IND_CFG_LO       7'h20
`define RPC_IND_CFG_HI       7'h3F
`define RPC_IND_TRK_LO       7'h40
`define RPC_IND_TRK_HI       7'h5F
`define RPC_IND_SIG_LO       7'h61
`define RPC_IND_SIG_HI       7'h7F

// Operation timing
`define RPC_OP_TIME_NS       490
`define RPC_CLK_PERIOD_NS    40
`define RPC_OP_CYCLES        ((`RPC_OP_TIME_NS + `RPC_CLK_PERIOD_NS - 1) / `RPC_CLK_PERIOD_NS)

`endif

// ---- verilog/rpc_pkg.sv ----
// Types shared by the receive payload conditioner files
package rpc_pkg;

  // Indirect access sequencer
  typedef enum logic [1:0] {
    RPC_ACC_IDLE = 2'b01,
    RPC_ACC_BUSY = 2'b10
  } rpc_acc_state_t;

  // Indirect space regions
  typedef enum logic [1:0] {
    RPC_REG_NONE  = 2'h0,
    RPC_REG_CFG   = 2'h1,
    RPC_REG_TRUNK = 2'h2,
    RPC_REG_SIG   = 2'h3
  } rpc_region_t;

endpackage : rpc_pkg

// ---- verilog/rpc_stream_if.sv ----
// Valid/ready word path between the conditioner and its output buffer
interface rpc_stream_if #(
  parameter int W = 18
);
  logic         s_valid;
  logic         s_ready;
  logic [W-1:0] s_data;
  logic         m_valid;
  logic         m_ready;
  logic [W-1:0] m_data;

  modport fifo (
    input  s_valid, s_data, m_ready,
    output s_ready, m_valid, m_data
  );

  modport user (
    output s_valid, s_data, m_ready,
    input  s_ready, m_valid, m_data
  );
endinterface : rpc_stream_if

// ---- verilog/rpc_skid_buffer.sv ----
// Two-entry buffer that holds conditioned slots while the receiver stalls
module rpc_skid_buffer
  import rpc_pkg::*;
#(
  parameter int W     = 18,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic  clk_sys_i,
  input  wire logic  reset_n_i,
  // Word path
  rpc_stream_if.fifo st
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0]   count_ff;
  logic          push;
  logic          pop;

  assign st.s_ready = (count_ff != (AW+1)'(DEPTH));
  assign st.m_valid = (count_ff != '0);
  assign st.m_data  = mem_ff[rd_ptr_ff];
  assign push       = st.s_valid & st.s_ready;
  assign pop        = st.m_valid & st.m_ready;

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

  // Storage written by index
  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_entry
      always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
          mem_ff[i] <= '0;
        end else if (push && (wr_ptr_ff == AW'(i))) begin
          mem_ff[i] <= st.s_data;
        end
      end
    end
  endgenerate

endmodule // rpc_skid_buffer

// ---- verilog/rpc_conditioner.sv ----
// Receive payload conditioner: indirect register access and per-slot conditioning
`include "rpc_consts.svh"

module rpc_conditioner
  import rpc_pkg::*;
#(
  parameter int SLOTS     = 32,
  parameter int OP_CYCLES = `RPC_OP_CYCLES,
  parameter int DEPTH     = 2
) (
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       reset_n_i,
  // Microprocessor port
  input  wire logic [7:0] cpu_addr_i,
  input  wire logic       cpu_wr_i,
  input  wire logic       cpu_rd_i,
  input  wire logic [7:0] cpu_wdata_i,
  output logic      [7:0] cpu_rdata_o,
  // Mode controls from the framer
  input  wire logic       pattern_direction_select_i,
  input  wire logic       slave_fractional_mode_i,
  // Received slot stream
  input  wire logic       in_valid_i,
  output logic            in_ready_o,
  input  wire logic [4:0] in_slot_i,
  input  wire logic [7:0] in_data_i,
  input  wire logic [3:0] in_sig_i,
  // Pattern generator/detector
  input  wire logic [7:0] pattern_gen_detector_data_i,
  output logic            pattern_gen_detector_take_o,
  output logic            pattern_gen_detector_valid_o,
  output logic      [7:0] pattern_gen_detector_data_o,
  // Conditioned stream toward the backplane
  output logic            out_valid_o,
  input  wire logic       out_ready_i,
  output logic      [4:0] out_slot_o,
  output logic      [7:0] receive_serial_data_o,
  output logic      [3:0] receive_signaling_out_o,
  output logic            receive_slave_clock_hold_o
);

  localparam int PW = 18;
  localparam int CW = $clog2(OP_CYCLES + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic rpc_region_t region_of(input logic [6:0] a);
    if (a >= `RPC_IND_CFG_LO && a <= `RPC_IND_CFG_HI) begin
      return RPC_REG_CFG;
    end else if (a >= `RPC_IND_TRK_LO && a <= `RPC_IND_TRK_HI) begin
      return RPC_REG_TRUNK;
    end else if (a >= `RPC_IND_SIG_LO && a <= `RPC_IND_SIG_HI) begin
      return RPC_REG_SIG;
    end else begin
      return RPC_REG_NONE;
    end
  endfunction

  function automatic logic [7:0] invert_mask(input logic sign, input logic [1:0] sel);
    logic [7:0] m;
    m = 8'h00;
    case ({sign, sel})
      3'h0:    m = 8'h00;
      3'h1:    m = 8'h55;
      3'h2:    m = 8'hAA;
      3'h3:    m = 8'hFF;
      3'h4:    m = 8'h80;
      3'h5:    m = 8'hD5;
      3'h6:    m = 8'h2A;
      3'h7:    m = 8'h7F;
      default: m = 8'h00;
    endcase
    return m;
  endfunction

  function automatic logic [7:0] milliwatt_byte(input logic alaw, input logic [2:0] ph);
    logic [7:0] b;
    b = 8'h00;
    case (ph)
      3'h0, 3'h3: b = alaw ? 8'h34 : 8'h1E;
      3'h1, 3'h2: b = alaw ? 8'h21 : 8'h0B;
      3'h4, 3'h7: b = alaw ? 8'hB4 : 8'h9E;
      3'h5, 3'h6: b = alaw ? 8'hA1 : 8'h8B;
      default:    b = 8'h00;
    endcase
    return b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Direct registers and indirect access sequencer

  rpc_acc_state_t state_ff;
  rpc_acc_state_t nxt_state;
  logic [CW-1:0]  cnt_ff;
  logic [7:0]     ctrl_ff;
  logic [7:0]     data_ff;
  logic           enable_ff;
  logic [7:0]     rdata_ff;
  logic [7:0]     cfg_ff   [SLOTS];
  logic [7:0]     trunk_ff [SLOTS];
  logic [3:0]     sig_ff   [SLOTS];

  wire            busy      = (state_ff == RPC_ACC_BUSY);
  wire            wr_config = cpu_wr_i && (cpu_addr_i == `RPC_ADDR_CONFIG);
  wire            wr_ctrl   = cpu_wr_i && (cpu_addr_i == `RPC_ADDR_CTRL);
  wire            wr_data   = cpu_wr_i && (cpu_addr_i == `RPC_ADDR_DATA);
  wire [7:0]      rst_config = `RPC_RST_CONFIG;
  wire rpc_region_t new_reg = region_of(cpu_wdata_i[6:0]);
  wire rpc_region_t cur_reg = region_of(ctrl_ff[6:0]);
  wire [4:0]      ind_idx   = ctrl_ff[4:0];
  wire            ind_read  = ctrl_ff[`RPC_CTRL_DIR_BIT];
  // start only when idle and in range
  wire            start     = wr_ctrl && !busy && (new_reg != RPC_REG_NONE);
  // completion after the full cycle count
  wire            done      = busy && (cnt_ff == '0);
  wire            ind_wr    = done && !ind_read;
  wire [7:0]      ind_rd_val =
      (cur_reg == RPC_REG_CFG)   ? cfg_ff[ind_idx]   :
      (cur_reg == RPC_REG_TRUNK) ? trunk_ff[ind_idx] :
      (cur_reg == RPC_REG_SIG)   ? {4'h0, sig_ff[ind_idx]} : 8'h00;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      RPC_ACC_IDLE: begin
        if (start) begin
          nxt_state = RPC_ACC_BUSY;
        end
      end
      RPC_ACC_BUSY: begin
        if (done) begin
          nxt_state = RPC_ACC_IDLE;
        end
      end
      default: nxt_state = RPC_ACC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      state_ff <= RPC_ACC_IDLE;
      cnt_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      // one operation cycle of clock counts
      if (start) begin
        cnt_ff <= CW'(OP_CYCLES - 1);
      end else if (busy && cnt_ff != '0) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      ctrl_ff   <= `RPC_RST_CTRL;
      enable_ff <= rst_config[`RPC_CONFIG_EN_BIT];
    end else begin
      if (wr_ctrl && !busy) begin
        ctrl_ff <= cpu_wdata_i;
      end
      if (wr_config) begin
        enable_ff <= cpu_wdata_i[`RPC_CONFIG_EN_BIT];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      data_ff <= `RPC_RST_DATA;
    end else if (done && ind_read) begin
      // read result lands in the buffer
      data_ff <= ind_rd_val;
    end else if (wr_data) begin
      data_ff <= cpu_wdata_i;
    end
  end

  // indirect write into the addressed table entry
  generate
    for (genvar i = 0; i < SLOTS; i++) begin : g_slot
      always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
          cfg_ff[i]   <= 8'h00;
          trunk_ff[i] <= 8'h00;
          sig_ff[i]   <= 4'h0;
        end else if (ind_wr && ind_idx == 5'(i)) begin
          if (cur_reg == RPC_REG_CFG) begin
            cfg_ff[i] <= data_ff;
          end
          if (cur_reg == RPC_REG_TRUNK) begin
            trunk_ff[i] <= data_ff;
          end
          if (cur_reg == RPC_REG_SIG) begin
            sig_ff[i] <= data_ff[3:0];
          end
        end
      end
    end
  endgenerate

  // Read-back of direct registers; unmapped offsets read zero
  wire [7:0] rd_mux =
      (cpu_addr_i == `RPC_ADDR_CONFIG) ? {7'h00, enable_ff} :
      (cpu_addr_i == `RPC_ADDR_STATUS) ? {busy, 7'h00}      :
      (cpu_addr_i == `RPC_ADDR_CTRL)   ? ctrl_ff            :
      (cpu_addr_i == `RPC_ADDR_DATA)   ? data_ff            : 8'h00;

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      rdata_ff <= 8'h00;
    end else if (cpu_rd_i) begin
      rdata_ff <= rd_mux;
    end
  end

  assign cpu_rdata_o = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Per-slot conditioning

  rpc_stream_if #(.W(PW)) buf_if ();

  logic [2:0] mw_phase_ff;
  logic       det_valid_ff;
  logic [7:0] det_data_ff;

  wire [7:0] slot_cfg = cfg_ff[in_slot_i];
  // master gate of every per-slot function
  wire       en       = enable_ff;
  wire       test_on  = en && slot_cfg[`RPC_CFG_TEST_BIT];
  wire       extract  = test_on && !pattern_direction_select_i;
  wire       replace  = test_on && pattern_direction_select_i;
  wire       trunk_on = en && slot_cfg[`RPC_CFG_DTRK_BIT];
  wire       mw_on    = en && slot_cfg[`RPC_CFG_MW_BIT];
  wire       use_trunk = !extract && trunk_on;
  wire       use_mw    = !extract && !trunk_on && mw_on;
  wire       use_prbs  = !extract && !trunk_on && !mw_on && replace;
  wire       use_inv   = en && !extract && !trunk_on && !mw_on && !replace;
  wire       push      = in_valid_i && buf_if.s_ready;
  wire [7:0] inv_data  = in_data_i ^ invert_mask(slot_cfg[`RPC_CFG_SIGN_BIT], slot_cfg[1:0]);
  wire [7:0] mw_data   = milliwatt_byte(slot_cfg[`RPC_CFG_ALAW_BIT], mw_phase_ff);
  wire [7:0] cond_data =
      use_trunk ? trunk_ff[in_slot_i]          :
      use_mw    ? mw_data                      :
      use_prbs  ? pattern_gen_detector_data_i  :
      use_inv   ? inv_data                     : in_data_i;
  wire [3:0] cond_sig  = (en && slot_cfg[`RPC_CFG_STRK_BIT]) ? sig_ff[in_slot_i] : in_sig_i;
  // slave clock held for a data-trunked slot in fractional mode
  wire       clk_hold  = slave_fractional_mode_i && trunk_on;

  assign buf_if.s_valid = in_valid_i;
  assign buf_if.s_data  = {clk_hold, cond_sig, cond_data, in_slot_i};
  assign buf_if.m_ready = out_ready_i;
  assign in_ready_o     = buf_if.s_ready;

  // one generator byte per replaced slot keeps the stream continuous
  assign pattern_gen_detector_take_o = push && use_prbs;

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      mw_phase_ff  <= 3'h0;
      det_valid_ff <= 1'b0;
      det_data_ff  <= 8'h00;
    end else begin
      if (push && use_mw) begin
        mw_phase_ff <= mw_phase_ff + 3'h1;
      end
      // extracted slots concatenate toward the detector
      det_valid_ff <= push && extract;
      if (push && extract) begin
        det_data_ff <= in_data_i;
      end
    end
  end

  assign pattern_gen_detector_valid_o = det_valid_ff;
  assign pattern_gen_detector_data_o  = det_data_ff;

  rpc_skid_buffer #(
    .W     (PW),
    .DEPTH (DEPTH)
  ) u_buf (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .st        (buf_if.fifo)
  );

  assign out_valid_o                = buf_if.m_valid;
  assign out_slot_o                 = buf_if.m_data[4:0];
  assign receive_serial_data_o      = buf_if.m_data[12:5];
  assign receive_signaling_out_o    = buf_if.m_data[16:13];
  assign receive_slave_clock_hold_o = buf_if.m_data[17];

endmodule // rpc_conditioner

// ---- test/rpc_checker.sv ----
// Port assertions for the receive payload conditioner
module rpc_checker (
  // Clock and reset
  input wire logic       clk_sys_i,
  input wire logic       reset_n_i,
  // Watched ports
  input wire logic       pattern_direction_select_i,
  input wire logic       in_valid_i,
  input wire logic       in_ready_o,
  input wire logic [7:0] in_data_i,
  input wire logic       pattern_gen_detector_take_o,
  input wire logic       pattern_gen_detector_valid_o,
  input wire logic [7:0] pattern_gen_detector_data_o,
  input wire logic       out_valid_o,
  input wire logic       out_ready_i,
  input wire logic [7:0] receive_serial_data_o,
  input wire logic [7:0] cpu_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys_i); endclocking
  wire logic acc = in_valid_i && in_ready_o;
  //////////////////////////////////////////
  sequence s_first; acc && !out_valid_o && !out_ready_i; endsequence
  sequence s_second; acc && !out_ready_i; endsequence
  property p_fill;
    disable iff (!reset_n_i) s_first ##1 s_second |=> !in_ready_o;
  endproperty
  property p_take;
    disable iff (!reset_n_i) pattern_gen_detector_take_o |-> acc && pattern_direction_select_i;
  endproperty
  property p_ext_cause;
    disable iff (!reset_n_i)
      pattern_gen_detector_valid_o |-> $past(acc && !pattern_direction_select_i);
  endproperty
  property p_ext_data;
    disable iff (!reset_n_i)
      pattern_gen_detector_valid_o |-> pattern_gen_detector_data_o == $past(in_data_i);
  endproperty
  property p_hold;
    disable iff (!reset_n_i)
      out_valid_o && !out_ready_i |=> out_valid_o && $stable(receive_serial_data_o);
  endproperty
  property p_rise;
    disable iff (!reset_n_i) $rose(out_valid_o) |-> $past(acc);
  endproperty
  property p_rst_out;
    !reset_n_i |=> !out_valid_o && in_ready_o;
  endproperty
  property p_rst_rd;
    !reset_n_i |=> cpu_rdata_o == 8'h00;
  endproperty
  //////////////////////////////////////////
  a_fill: assert property (p_fill) else $error("buffer took a third word");
  a_take: assert property (p_take) else $error("generator byte taken wrongly");
  a_ext_cause: assert property (p_ext_cause) else $error("stray extraction");
  a_ext_data: assert property (p_ext_data) else $error("extracted byte altered");
  a_hold: assert property (p_hold) else $error("output word changed while stalled");
  a_rise: assert property (p_rise) else $error("output word without input");
  a_rst_out: assert property (p_rst_out) else $error("buffer not empty after reset");
  a_rst_rd: assert property (p_rst_rd) else $error("read data not cleared by reset");
endmodule // rpc_checker

bind rpc_conditioner rpc_checker u_chk (
  .clk_sys_i, .reset_n_i, .pattern_direction_select_i, .in_valid_i, .in_ready_o,
  .in_data_i, .pattern_gen_detector_take_o, .pattern_gen_detector_valid_o,
  .pattern_gen_detector_data_o, .out_valid_o, .out_ready_i, .receive_serial_data_o,
  .cpu_rdata_o
);

// ---- test/rpc_far_model.sv ----
// Backplane receiver and pattern generator on the conditioner's far side
module rpc_far_model #(
  parameter logic [7:0] GEN_SEED = 8'h3A
) (
  // Clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       reset_n_i,
  // Scenario controls
  input  wire logic       stall_i,
  input  wire logic       fast_i,
  // Conditioner side
  input  wire logic       take_i,
  output logic            out_ready_o,
  output logic      [7:0] gen_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tick_ff;
  // Slow mode accepts every other cycle
  always_ff @(negedge clk_sys_i) tick_ff <= reset_n_i ? ~tick_ff : 1'b0;
  assign out_ready_o = !stall_i && (fast_i || tick_ff);
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) gen_data_o <= GEN_SEED;
    else if (take_i) gen_data_o <= gen_data_o + 8'h01;
  end
endmodule // rpc_far_model

// ---- test/tb_top.sv ----
// Self-checking bench for the receive payload conditioner
`include "rpc_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] SEED = 8'h3A;
  localparam int OPC = `RPC_OP_CYCLES;
  localparam logic [7:0] INV[8] = '{8'h00, 8'h55, 8'hAA, 8'hFF, 8'h80, 8'hD5, 8'h2A, 8'h7F};
  localparam logic [7:0] RA[5] = '{8'h5C, 8'h5D, 8'h5E, 8'h5F, 8'h10};
  logic clk_sys_i = 1'b0, reset_n_i = 1'b0, cpu_wr = 1'b0, cpu_rd = 1'b0;
  logic pds = 1'b0, frac = 1'b0, in_valid = 1'b0, stall = 1'b0, fast = 1'b0;
  logic [7:0] cpu_addr = 8'h00, cpu_wdata = 8'h00, in_data = 8'h00;
  logic [4:0] in_slot = 5'h00, oslot;
  logic [3:0] in_sig = 4'h0, osig;
  logic [7:0] rdata, gen, det_d, sd;
  logic in_ready, take, det_v, out_valid, out_ready, hold;
  logic [17:0] outq[$];
  logic [7:0] detq[$];
  int n_errors = 0;
  int cmp_count = 0;
  always #20 clk_sys_i = ~clk_sys_i;
  rpc_conditioner uut (
    .clk_sys_i, .reset_n_i, .cpu_addr_i(cpu_addr), .cpu_wr_i(cpu_wr), .cpu_rd_i(cpu_rd),
    .cpu_wdata_i(cpu_wdata), .cpu_rdata_o(rdata), .pattern_direction_select_i(pds),
    .slave_fractional_mode_i(frac), .in_valid_i(in_valid), .in_ready_o(in_ready),
    .in_slot_i(in_slot), .in_data_i(in_data), .in_sig_i(in_sig),
    .pattern_gen_detector_data_i(gen), .pattern_gen_detector_take_o(take),
    .pattern_gen_detector_valid_o(det_v), .pattern_gen_detector_data_o(det_d),
    .out_valid_o(out_valid), .out_ready_i(out_ready), .out_slot_o(oslot),
    .receive_serial_data_o(sd), .receive_signaling_out_o(osig),
    .receive_slave_clock_hold_o(hold));
  rpc_far_model #(.GEN_SEED(SEED)) u_far (
    .clk_sys_i, .reset_n_i, .stall_i(stall), .fast_i(fast), .take_i(take),
    .out_ready_o(out_ready), .gen_data_o(gen));
  always @(posedge clk_sys_i) begin
    if (reset_n_i && out_valid && out_ready) outq.push_back({oslot, sd, osig, hold});
    if (reset_n_i && det_v) detq.push_back(det_d);
  end
  ////////////////////////////////////////////////
  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(negedge clk_sys_i);
    cpu_wr = 1'b0;
    @(negedge clk_sys_i);
  endtask
  task automatic rd(logic [7:0] a, output logic [7:0] d);
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(negedge clk_sys_i);
    cpu_rd = 1'b0;
    d = rdata;
    @(negedge clk_sys_i);
  endtask
  // Polls status with the read strobe held, one sample per cycle
  task automatic idle(output int ones);
    ones = 0;
    cpu_addr = `RPC_ADDR_STATUS;
    cpu_rd = 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk_sys_i);
      if (rdata[`RPC_STATUS_BUSY_BIT] !== 1'b1) break;
      ones++;
    end
    cpu_rd = 1'b0;
    @(negedge clk_sys_i);
    if (ones == 40) begin
      n_errors++;
      $display("ERROR busy expected 0 seen 1");
    end
  endtask
  task automatic iwr(logic [6:0] a, logic [7:0] d);
    int n;
    wr(`RPC_ADDR_DATA, d);
    wr(`RPC_ADDR_CTRL, {1'b0, a});
    idle(n);
  endtask
  task automatic ird(logic [6:0] a, logic [7:0] exp);
    int n;
    logic [7:0] d;
    wr(`RPC_ADDR_CTRL, {1'b1, a});
    idle(n);
    rd(`RPC_ADDR_DATA, d);
    chk("indirect", exp, d);
  endtask
  task automatic send(logic [7:0] d, bit last);
    in_slot = 5'h05;
    in_data = d;
    in_sig = 4'h3;
    in_valid = 1'b1;
    for (int i = 0; i < 20 && in_ready !== 1'b1; i++) @(negedge clk_sys_i);
    @(negedge clk_sys_i);
    if (last) begin
      in_valid = 1'b0;
      @(negedge clk_sys_i);
    end
  endtask
  task automatic expect_out(logic [7:0] d, logic [3:0] g, logic h);
    logic [17:0] w;
    for (int i = 0; i < 20 && outq.size() == 0; i++) @(negedge clk_sys_i);
    w = (outq.size() != 0) ? outq.pop_front() : 'x;
    chk("slot", 8'h05, {3'h0, w[17:13]});
    chk("data", d, w[12:5]);
    chk("signaling", {4'h0, g}, {4'h0, w[4:1]});
    chk("hold", {7'h00, h}, {7'h00, w[0]});
  endtask
  task automatic run(logic [7:0] cfg, logic [7:0] d, logic [7:0] e, logic [3:0] g, logic h);
    iwr(7'h25, cfg);
    send(d, 1'b1);
    expect_out(e, g, h);
  endtask
  task automatic stop_test();
    $display("Comparisons %0d, errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////
  initial begin
    #(40ns * 20000);
    n_errors++;
    stop_test();
  end
  initial begin
    logic [7:0] d;
    int ones;
    repeat (16) @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(RA[i], d);
      chk("reset value", 8'h00, d);
    end
    iwr(7'h45, 8'h96);
    wr(`RPC_ADDR_CTRL, 8'hC5);
    idle(ones);
    // The write's idle cycle hides the first busy cycle from the poll
    chk("busy cycles", 8'(OPC - 1), 8'(ones));
    wr(`RPC_ADDR_CTRL, 8'hC5);
    wr(`RPC_ADDR_CTRL, 8'h65);
    idle(ones);
    rd(`RPC_ADDR_CTRL, d);
    chk("ctrl", 8'hC5, d);
    rd(`RPC_ADDR_DATA, d);
    chk("buffer", 8'h96, d);
    iwr(7'h65, 8'hF9);
    ird(7'h65, 8'h09);
    wr(`RPC_ADDR_CTRL, 8'hE0);
    rd(`RPC_ADDR_STATUS, d);
    chk("busy invalid", 8'h00, d);
    wr(`RPC_ADDR_CONFIG, 8'h01);
    ird(7'h45, 8'h96);
    for (int i = 0; i < 8; i++) run(i[7:0], 8'hC5, 8'hC5 ^ INV[i], 4'h3, 1'b0);
    run(8'h47, 8'hC5, 8'h96, 4'h3, 1'b0);
    frac = 1'b1;
    run(8'h47, 8'hC5, 8'h96, 4'h3, 1'b1);
    frac = 1'b0;
    run(8'h20, 8'h11, 8'h11, 4'h9, 1'b0);
    run(8'h50, 8'hC5, 8'h96, 4'h3, 1'b0);
    run(8'hC0, 8'h5B, 8'h5B, 4'h3, 1'b0);
    chk("extracted", 8'h5B, (detq.size() != 0) ? detq.pop_front() : 8'hxx);
    pds = 1'b1;
    iwr(7'h25, 8'h87);
    send(8'h5B, 1'b0);
    send(8'h5C, 1'b1);
    expect_out(SEED, 4'h3, 1'b0);
    expect_out(SEED + 8'h01, 4'h3, 1'b0);
    wr(`RPC_ADDR_CONFIG, 8'h00);
    frac = 1'b1;
    run(8'h47, 8'hC5, 8'hC5, 4'h3, 1'b0);
    stall = 1'b1;
    send(8'h01, 1'b0);
    send(8'h02, 1'b0);
    chk("in_ready full", 8'h00, {7'h00, in_ready});
    in_valid = 1'b0;
    stall = 1'b0;
    fast = 1'b1;
    expect_out(8'h01, 4'h3, 1'b0);
    expect_out(8'h02, 4'h3, 1'b0);
    stop_test();
  end
endmodule // tb_top
